/* File: swd_pkg.sv */
// Purpose: Shared constants for the single-wire debug link block
// Assumes: 100 MHz mclk; debug clock is a one-cycle enable derived inside
// Notes:   Command codes are the opcodes the serial engine decodes
package swd_pkg;
	// Bit timing in debug clock ticks
	localparam int unsigned BIT_TICKS      = 16;   // Nominal bit time
	localparam int unsigned SAMPLE_TICK    = 10;   // Host-to-target sample point
	localparam int unsigned ONE_PULSE_TICK = 7;    // Speedup pulse when sending one
	localparam int unsigned ZERO_LOW_TICKS = 13;   // Low time when sending zero
	localparam int unsigned TIMEOUT_TICKS  = 512;  // Inactivity timeout
	localparam int unsigned SYNC_REQ_TICKS = 128;  // Least low time of sync request
	localparam int unsigned SYNC_WAIT      = 16;   // Wait before sync answer
	localparam int unsigned SYNC_LOW       = 128;  // Low time of sync answer
	localparam int unsigned TURN_TICKS     = 16;   // Turnaround delay
	// Alternate clock divider (debug tick every N mclk)
	localparam int unsigned ALT_DIV        = 4;
	// Command codes
	localparam logic [7:0] CMD_BACKGROUND  = 8'h90;
	localparam logic [7:0] CMD_RD_STATUS   = 8'he4;
	localparam logic [7:0] CMD_WR_CONTROL  = 8'hc4;
	localparam logic [7:0] CMD_RD_BYTE     = 8'he0;
	localparam logic [7:0] CMD_WR_BYTE     = 8'hc0;
	localparam logic [7:0] CMD_RD_BKPT     = 8'he2;
	localparam logic [7:0] CMD_WR_BKPT     = 8'hc2;
	localparam logic [7:0] CMD_GO          = 8'h08;
	localparam logic [7:0] CMD_STEP        = 8'h10;
	localparam logic [7:0] CMD_RD_A        = 8'h68;
	localparam logic [7:0] CMD_WR_A        = 8'h48;
	// Status and control field positions
	localparam int unsigned SC_ENABLE      = 7;    // Debug enable
	localparam int unsigned SC_HALTED      = 6;    // Halted mode flag (read only)
	localparam int unsigned SC_CLKSEL      = 2;    // Debug clock select
	localparam int unsigned SC_BKPT_EN     = 1;    // Breakpoint enable
	localparam logic [7:0]  SC_RESET       = 8'h00; // Control reset value
endpackage : swd_pkg

/* File: swd_tick.sv */
// Purpose: Debug clock enable from bus clock or divided alternate source
// Assumes: Synchronous active-high reset
// Notes:   Output is a one-cycle tick at the debug clock rate
`timescale 1ns/100ps
module swd_tick (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic ce,
	// Control
	input  wire logic alt_sel,
	// Tick
	output logic      tick
);
	logic [7:0] div_r;   // Divider for alternate source

	// Free divider for the alternate clock
	always_ff @(posedge mclk) begin
		if (reset)
			div_r <= 8'h00;
		else if (ce)
			div_r <= (div_r == 8'(swd_pkg::ALT_DIV - 1)) ? 8'h00 : div_r + 8'h01;
	end

	// Bus clock ticks every cycle; alternate ticks once per divide
	assign tick = ce & (alt_sel ? (div_r == 8'h00) : 1'b1);
endmodule : swd_tick

/* File: swd_link.sv */
// Purpose: Target-side single-wire background debug link
// Assumes: Pin is pseudo-open-drain with on-chip pullup; ports synchronous to mclk
// Notes:   Commands handled: background, status/control, byte access, breakpoint,
//          go, single step, accumulator access
// Functional notes
// - MSB first, sixteen debug clocks per bit
// - Time out after 512 clocks between edges
// - Timeout aborts command without side effects
// - Detect start, sample ten clocks later
// - Pin undriven while host sends
// - Sending one: speedup pulse at clock seven
// - Sending zero: low thirteen, then pulse
// - Control bit selects debug clock source
// - Pin level at reset selects halted mode
// - Pullup high selects normal run at reset
// - Answer speed request with timed pulse
// - Register, step, go only while halted
// - Memory and status commands anytime
// - Background command wakes from stop/wait
// - Oscillator kept running in stop if enabled
// - Watchdog held off while halted
// - Debug registers not memory mapped
// - One hardware address breakpoint
// - Sync: wait 16, low 128, pulse, release
// - 8-bit command code, 16-clock turnaround
`timescale 1ns/100ps
module swd_link (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        ce,
	// Debug wire pin
	input  wire logic        debug_wire_pin_i,
	output logic             debug_wire_pin_o,
	output logic             debug_wire_pin_oe,
	// Processor status
	input  wire logic        cpu_in_low_power,
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_addr_valid,
	input  wire logic [7:0]  cpu_acc,
	// Memory access port
	output logic             mem_req,
	output logic             mem_we,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	// Processor control
	output logic             halted_debug_mode,
	output logic             cpu_go,
	output logic             single_step_command,
	output logic             cpu_wake,
	output logic             acc_we,
	output logic [7:0]       acc_wdata,
	output logic             bkpt_hit,
	output logic             osc_keep_on,
	output logic             watchdog_hold
);
	typedef enum logic [2:0] {SWD_IDLE, SWD_RX, SWD_TX, SWD_TURN, SWD_SYNCW, SWD_SYNCL,
		SWD_SYNCP} swd_state_e;

	swd_state_e  state_r;     // Link state
	logic        s1_r, s2_r;  // Pin synchronizer
	logic        s3_r;        // Previous synced level
	logic [9:0]  tmo_r;       // Ticks since last host edge
	logic [7:0]  cnt_r;       // Tick counter within bit or phase
	logic [7:0]  low_r;       // Ticks of low level for sync detect
	logic [5:0]  nbit_r;      // Bits left in current field
	logic [23:0] rx_r;        // Shift-in register
	logic [15:0] tx_r;        // Shift-out register
	logic [7:0]  cmd_r;       // Current command code
	logic [2:0]  phase_r;     // Phase within command
	logic [7:0]  sc_r;        // Status and control register
	logic [15:0] bkpt_r;      // Breakpoint address
	logic        halt_r;      // Halted debug mode
	logic [1:0]  boot_r;      // Cycles left until pin level capture
	logic        tick;        // Debug clock enable
	logic        fall;        // Synced falling edge
	logic        ftick;       // Edge gated onto a tick

	// Debug clock source from control bit
	swd_tick u_tick (
		.mclk    (mclk),
		.reset   (reset),
		.ce      (ce),
		.alt_sel (sc_r[swd_pkg::SC_CLKSEL]),
		.tick    (tick)
	);

	// Two-stage synchronizer; only s2 onward is examined
	always_ff @(posedge mclk) begin
		if (reset) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else if (ce) begin
			s1_r <= debug_wire_pin_i;
			s2_r <= s1_r;
			if (tick)
				s3_r <= s2_r;
		end
	end
	assign fall  = s3_r & ~s2_r;
	assign ftick = fall & tick;

	// Pin drive decode; pin released while host sends
	always_comb begin
		debug_wire_pin_oe = 1'b0;
		debug_wire_pin_o  = 1'b0;
		case (state_r)
			SWD_TX: begin
				if (tx_r[15]) begin
					// One: speedup pulse at tick seven
					debug_wire_pin_oe = (cnt_r == 8'(swd_pkg::ONE_PULSE_TICK));
					debug_wire_pin_o  = 1'b1;
				end else begin
					// Zero: hold low, then speedup pulse
					debug_wire_pin_oe = (cnt_r <= 8'(swd_pkg::ZERO_LOW_TICKS));
					debug_wire_pin_o  = (cnt_r == 8'(swd_pkg::ZERO_LOW_TICKS));
				end
			end
			SWD_SYNCL: begin
				debug_wire_pin_oe = 1'b1;
				debug_wire_pin_o  = 1'b0;
			end
			SWD_SYNCP: begin
				debug_wire_pin_oe = 1'b1;
				debug_wire_pin_o  = 1'b1;
			end
			default: begin
				debug_wire_pin_oe = 1'b0;
				debug_wire_pin_o  = 1'b0;
			end
		endcase
	end

	// Long-low measurement for sync requests
	always_ff @(posedge mclk) begin
		if (reset)
			low_r <= 8'h00;
		else if (tick) begin
			// Own drive is never a host request
			if (s2_r || debug_wire_pin_oe)
				low_r <= 8'h00;
			else if (low_r != 8'hff)
				low_r <= low_r + 8'h01;
		end
	end

	// Main link engine
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r   <= SWD_IDLE;
			tmo_r     <= 10'h000;
			cnt_r     <= 8'h00;
			nbit_r    <= 6'h00;
			rx_r      <= 24'h000000;
			tx_r      <= 16'h0000;
			cmd_r     <= 8'h00;
			phase_r   <= 3'h0;
			sc_r      <= swd_pkg::SC_RESET;
			bkpt_r    <= 16'h0000;
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= 16'h0000;
			mem_wdata <= 8'h00;
			cpu_go    <= 1'b0;
			single_step_command <= 1'b0;
			cpu_wake  <= 1'b0;
			acc_we    <= 1'b0;
			acc_wdata <= 8'h00;
		end else if (ce) begin
			// Single-cycle strobes
			mem_req  <= 1'b0;
			cpu_go   <= 1'b0;
			single_step_command <= 1'b0;
			cpu_wake <= 1'b0;
			acc_we   <= 1'b0;
			if (tick) begin
				// Saturates so a long gap never reaches a sample point again
				cnt_r <= (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
				tmo_r <= ftick ? 10'h000 : (tmo_r == 10'h3ff ? tmo_r : tmo_r + 10'h001);
				case (state_r)
					SWD_IDLE: begin
						if (s2_r && low_r >= 8'(swd_pkg::SYNC_REQ_TICKS)) begin
							// Sync request: low for at least 128 ticks, now released
							cnt_r   <= 8'h00;
							tmo_r   <= 10'h000;
							state_r <= SWD_SYNCW;
						end else if (ftick) begin
							// Start of a command code
							cnt_r   <= 8'h00;
							nbit_r  <= 6'd8;
							phase_r <= 3'h0;
							state_r <= SWD_RX;
						end
					end
					SWD_RX: begin
						if (s2_r && low_r >= 8'(swd_pkg::SYNC_REQ_TICKS)) begin
							cnt_r   <= 8'h00;
							tmo_r   <= 10'h000;
							state_r <= SWD_SYNCW;
						end else if (tmo_r == 10'(swd_pkg::TIMEOUT_TICKS - 1)) begin
							state_r <= SWD_IDLE;
						end else if (ftick) begin
							cnt_r <= 8'h00;
						end else if (cnt_r == 8'(swd_pkg::SAMPLE_TICK) && nbit_r != 6'h00) begin
							rx_r   <= {rx_r[22:0], s2_r};
							nbit_r <= nbit_r - 6'h01;
							if (nbit_r == 6'h01) begin
								// Field complete: act on it
								phase_r <= phase_r + 3'h1;
								if (phase_r == 3'h0) begin
									cmd_r <= {rx_r[6:0], s2_r};
									case ({rx_r[6:0], s2_r})
										swd_pkg::CMD_RD_STATUS: begin
											tx_r    <= {sc_r[7], halt_r, sc_r[5:0], 8'h00};
											nbit_r  <= 6'd8;
											cnt_r   <= 8'hff;   // No drive before host edge
											state_r <= SWD_TX;
										end
										swd_pkg::CMD_RD_BKPT: begin
											tx_r    <= bkpt_r;
											nbit_r  <= 6'd16;
											cnt_r   <= 8'hff;
											state_r <= SWD_TX;
										end
										swd_pkg::CMD_WR_CONTROL: nbit_r <= 6'd8;
										swd_pkg::CMD_WR_BKPT:    nbit_r <= 6'd16;
										swd_pkg::CMD_RD_BYTE:    nbit_r <= 6'd16;
										swd_pkg::CMD_WR_BYTE:    nbit_r <= 6'd24;
										swd_pkg::CMD_WR_A: begin
											// Accepted only while halted
											if (halt_r) nbit_r <= 6'd8;
											else state_r <= SWD_IDLE;
										end
										swd_pkg::CMD_BACKGROUND, swd_pkg::CMD_GO,
										swd_pkg::CMD_STEP, swd_pkg::CMD_RD_A: begin
											cnt_r   <= 8'h00;
											state_r <= SWD_TURN;
										end
										default: state_r <= SWD_IDLE;
									endcase
								end else begin
									// Argument field received; effects only now
									case (cmd_r)
										swd_pkg::CMD_WR_CONTROL: begin
											sc_r    <= {rx_r[6:0], s2_r};
											state_r <= SWD_IDLE;
										end
										swd_pkg::CMD_WR_BKPT: begin
											bkpt_r  <= {rx_r[14:0], s2_r};
											state_r <= SWD_IDLE;
										end
										swd_pkg::CMD_RD_BYTE: begin
											mem_addr <= {rx_r[14:0], s2_r};
											mem_req  <= 1'b1;
											mem_we   <= 1'b0;
											cnt_r    <= 8'h00;
											state_r  <= SWD_TURN;
										end
										swd_pkg::CMD_WR_BYTE: begin
											mem_addr  <= rx_r[22:7];
											mem_wdata <= {rx_r[6:0], s2_r};
											mem_req   <= 1'b1;
											mem_we    <= 1'b1;
											state_r   <= SWD_IDLE;
										end
										swd_pkg::CMD_WR_A: begin
											acc_wdata <= {rx_r[6:0], s2_r};
											acc_we    <= 1'b1;
											state_r   <= SWD_IDLE;
										end
										default: state_r <= SWD_IDLE;
									endcase
								end
							end
						end
					end
					SWD_TURN: begin
						if (cnt_r == 8'(swd_pkg::TURN_TICKS - 1)) begin
							state_r <= SWD_IDLE;
							case (cmd_r)
								swd_pkg::CMD_BACKGROUND: begin
									if (sc_r[swd_pkg::SC_ENABLE])
										cpu_wake <= 1'b1;
								end
								swd_pkg::CMD_GO:   cpu_go <= halt_r;
								swd_pkg::CMD_STEP: single_step_command <= halt_r;
								swd_pkg::CMD_RD_A: begin
									if (halt_r) begin
										tx_r    <= {cpu_acc, 8'h00};
										nbit_r  <= 6'd8;
										state_r <= SWD_TX;
									end
								end
								swd_pkg::CMD_RD_BYTE: begin
									tx_r    <= {mem_rdata, 8'h00};
									nbit_r  <= 6'd8;
									state_r <= SWD_TX;
								end
								default: state_r <= SWD_IDLE;
							endcase
						end
					end
					SWD_TX: begin
						if (tmo_r == 10'(swd_pkg::TIMEOUT_TICKS - 1))
							state_r <= SWD_IDLE;
						else if (ftick)
							cnt_r <= 8'h00;
						else if (cnt_r == 8'(swd_pkg::BIT_TICKS - 1) && nbit_r != 6'h00) begin
							tx_r   <= {tx_r[14:0], 1'b0};
							nbit_r <= nbit_r - 6'h01;
							if (nbit_r == 6'h01)
								state_r <= SWD_IDLE;
						end
					end
					SWD_SYNCW: begin
						if (cnt_r == 8'(swd_pkg::SYNC_WAIT - 1)) begin
							cnt_r   <= 8'h00;
							state_r <= SWD_SYNCL;
						end
					end
					SWD_SYNCL: begin
						if (cnt_r == 8'(swd_pkg::SYNC_LOW - 1))
							state_r <= SWD_SYNCP;
					end
					SWD_SYNCP: state_r <= SWD_IDLE;
					default:   state_r <= SWD_IDLE;
				endcase
			end
		end
	end

	// Halted mode: pin level after reset, then commands and breakpoint hits
	always_ff @(posedge mclk) begin
		if (reset) begin
			halt_r <= 1'b0;
			boot_r <= 2'h3;
		end else if (ce) begin
			// Synchronizer shows its reset level for two cycles
			if (boot_r != 2'h0)
				boot_r <= boot_r - 2'h1;
			if (boot_r == 2'h1)
				halt_r <= ~s2_r;
			else if (cpu_wake || (bkpt_hit))
				halt_r <= 1'b1;
			else if (cpu_go || single_step_command)
				halt_r <= 1'b0;
		end
	end

	// Address breakpoint compare, registers reached only serially
	always_ff @(posedge mclk) begin
		if (reset)
			bkpt_hit <= 1'b0;
		else if (ce)
			bkpt_hit <= sc_r[swd_pkg::SC_BKPT_EN] & cpu_addr_valid & ~halt_r
				& (cpu_addr == bkpt_r);
	end

	// System side effects
	assign halted_debug_mode = halt_r;
	assign osc_keep_on   = sc_r[swd_pkg::SC_ENABLE] & cpu_in_low_power;
	assign watchdog_hold = halt_r;

	// Zero sent: pin never driven after the pulse at tick thirteen
	zero_drive_a: assert property (@(posedge mclk) disable iff (reset)
		(state_r == SWD_TX && !tx_r[15] && cnt_r > 8'd13) |-> !debug_wire_pin_oe)
		else $error("zero bit drive too long");
	one_pulse_a: assert property (@(posedge mclk) disable iff (reset)
		(debug_wire_pin_oe && state_r == SWD_TX && tx_r[15]) |-> cnt_r == 8'd7)
		else $error("one pulse misplaced");
	rx_release_a: assert property (@(posedge mclk) disable iff (reset)
		(state_r == SWD_RX || state_r == SWD_IDLE || state_r == SWD_SYNCW)
		|-> !debug_wire_pin_oe)
		else $error("pin driven while host sends");
	timeout_a: assert property (@(posedge mclk) disable iff (reset)
		(tmo_r >= 10'd512) |-> state_r == SWD_IDLE)
		else $error("link not timed out");
	go_halt_a: assert property (@(posedge mclk) disable iff (reset)
		cpu_go |-> $past(halt_r))
		else $error("go while running");
	wdog_hold_a: assert property (@(posedge mclk) disable iff (reset)
		watchdog_hold == halted_debug_mode)
		else $error("watchdog not held");
	sync_pulse_a: assert property (@(posedge mclk) disable iff (reset)
		(state_r == SWD_SYNCP) |-> debug_wire_pin_oe && debug_wire_pin_o)
		else $error("sync pulse missing");
	bkpt_cmp_a: assert property (@(posedge mclk) disable iff (reset || !ce)
		bkpt_hit |-> $past(cpu_addr) == bkpt_r)
		else $error("breakpoint mismatch");
endmodule : swd_link

/* File: swd_pod.sv */
// Purpose: Behavioural debug pod that opens every bit time on the wire
// Assumes: Wire resolved in the bench with a pullup; pod released means high
// Notes:   tk is mclk cycles per debug tick; drive changes follow a rising edge
`timescale 1ns/100ps
module swd_pod (
	// Clock and wire level
	input  wire logic mclk,
	input  wire logic pin,
	// Pod drive
	output logic      pod_o,
	output logic      pod_oe
);
	int tk = 1; // Mclk cycles per debug tick

	// Released at time zero
	initial begin
		pod_o  = 1'b1;
		pod_oe = 1'b0;
	end

	// Drive or release for n ticks
	task automatic drv(input logic oe, input logic o, input int n);
		pod_oe <= oe;
		pod_o  <= o;
		repeat (n * tk) @(posedge mclk);
	endtask : drv

	// Host bit: falling edge, level, release; margins cover sync delay
	task automatic tx_bit(input logic b);
		drv(1'b1, 1'b0, b ? 4 : 15);
		drv(1'b1, 1'b1, b ? 12 : 1);  // Both levels driven actively
		drv(1'b0, 1'b1, 4);
	endtask : tx_bit

	// Byte, highest bit first
	task automatic tx8(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) tx_bit(v[i]);
	endtask : tx8

	// Two bytes, high byte first
	task automatic tx16(input logic [15:0] v);
		tx8(v[15:8]);
		tx8(v[7:0]);
	endtask : tx16

	// Target bit: short low, release before the pulse, sample mid bit
	task automatic rx_bit(output logic b);
		drv(1'b1, 1'b0, 3);
		drv(1'b0, 1'b1, 7);
		#1 b = pin;
		drv(1'b0, 1'b1, 10);
	endtask : rx_bit

	// Byte from target
	task automatic rx8(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) rx_bit(v[i]);
	endtask : rx8

	// Long low request, one-cycle pulse, then time the answer in mclk
	task automatic sync(output int lo);
		int w;
		lo = 0;
		w  = 0;
		pod_oe <= 1'b1;
		pod_o  <= 1'b0;
		repeat (600 * tk) @(posedge mclk);
		pod_o <= 1'b1;
		@(posedge mclk);
		pod_oe <= 1'b0;
		#1;
		while (pin === 1'b1 && w < 400) begin
			@(posedge mclk);
			#1 w++;
		end
		while (pin === 1'b0 && lo < 1000) begin
			@(posedge mclk);
			#1 lo++;
		end
	endtask : sync
endmodule : swd_pod

/* File: swd_link_test.sv */
// Purpose: Self-checking bench for the single-wire debug link
// Assumes: Bus clock ticks after reset; alternate tick every ALT_DIV mclk
// Notes:   Pod model drives the wire; memory and pulse counts kept here
`timescale 1ns/100ps
module swd_link_test;
	// Design inputs
	logic        mclk      = 1'b0;
	logic        reset     = 1'b1;
	logic        ce        = 1'b1;
	logic        low_pwr   = 1'b0;
	logic [15:0] cpu_addr  = 16'h0000;
	logic        addr_vld  = 1'b0;
	logic [7:0]  cpu_acc   = 8'h00;
	logic [7:0]  mem_rdata = 8'h00;
	// Design outputs
	logic        pin_o, pin_oe, mem_req, mem_we, halted, go, step, wake;
	logic        acc_we, bkpt_hit, osc_on, wd_hold;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata, acc_wdata;
	// Pod drive and wire with pullup
	logic        pod_o, pod_oe;
	wire         pin = pin_oe ? pin_o : (pod_oe ? pod_o : 1'b1);
	// Counters and reference model
	int          error_cnt, samples_checked, lo;
	int          n_go, n_step, n_wake, n_accw, n_wr, n_conf;
	logic [7:0]  mem_m [int];
	logic [15:0] wr_a, v16, w16;
	logic [7:0]  wr_d, v8, d8, ctrl_m;
	logic        halt_m;

	// Free-running clock
	initial forever #5 mclk = ~mclk;

	swd_link u_swd_link (
		.mclk(mclk), .reset(reset), .ce(ce),
		.debug_wire_pin_i(pin), .debug_wire_pin_o(pin_o), .debug_wire_pin_oe(pin_oe),
		.cpu_in_low_power(low_pwr), .cpu_addr(cpu_addr), .cpu_addr_valid(addr_vld),
		.cpu_acc(cpu_acc), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .halted_debug_mode(halted),
		.cpu_go(go), .single_step_command(step), .cpu_wake(wake), .acc_we(acc_we),
		.acc_wdata(acc_wdata), .bkpt_hit(bkpt_hit), .osc_keep_on(osc_on),
		.watchdog_hold(wd_hold)
	);

	swd_pod u_pod (.mclk(mclk), .pin(pin), .pod_o(pod_o), .pod_oe(pod_oe));

	// Memory model, pulse counts and drive clashes
	always @(posedge mclk) begin
		if (mem_req === 1'b1 && mem_we === 1'b1) begin
			mem_m[int'(mem_addr)] = mem_wdata;
			wr_a = mem_addr;
			wr_d = mem_wdata;
			n_wr++;
		end else if (mem_req === 1'b1) begin
			mem_rdata <= mem_m.exists(int'(mem_addr)) ? mem_m[int'(mem_addr)] : 8'h00;
		end
		n_go   += (go === 1'b1);
		n_step += (step === 1'b1);
		n_wake += (wake === 1'b1);
		n_accw += (acc_we === 1'b1);
		n_conf += (pod_oe === 1'b1 && pin_oe === 1'b1 && pod_o !== pin_o);
	end

	// Value compare
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	// Count compare
	task automatic chk_cnt(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_cnt

	// Counts and verdict
	task automatic results;
		$display("Checks %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// Reset with the pod holding a chosen wire level past release
	task automatic rst(input logic lvl);
		@(posedge mclk);
		reset <= 1'b1;
		u_pod.tk = 1;
		u_pod.drv(~lvl, 1'b0, 8);
		reset <= 1'b0;
		u_pod.drv(~lvl, 1'b0, 4);
		u_pod.drv(1'b0, 1'b1, 6);
		halt_m = ~lvl;
		ctrl_m = 8'h00;
	endtask : rst

	// Code followed by the turnaround wait
	task automatic cmd(input logic [7:0] c);
		u_pod.tx8(c);
		u_pod.drv(1'b0, 1'b1, 20);
	endtask : cmd

	// Control write kept in the model
	task automatic wr_ctrl(input logic [7:0] c);
		u_pod.tx8(swd_pkg::CMD_WR_CONTROL);
		u_pod.tx8(c);
		ctrl_m = c;
		u_pod.drv(1'b0, 1'b1, 20);
	endtask : wr_ctrl

	// Status read against the model
	task automatic rd_status;
		u_pod.tx8(swd_pkg::CMD_RD_STATUS);
		u_pod.rx8(v8);
		chk_val(v8, {ctrl_m[7], halt_m, ctrl_m[5:0]});
	endtask : rd_status

	// Main sequence
	initial begin
		void'($urandom(32'h94fbedf1));
		rst(1'b0);
		chk_val(halted, 1'b1);
		rst(1'b1);
		chk_val({halted, wd_hold}, 2'b00);
		rd_status();
		u_pod.sync(lo);
		chk_cnt(lo, 128);
		u_pod.drv(1'b0, 1'b1, 20);
		// Disabled and running: background, go and accumulator write have no effect
		@(posedge mclk) low_pwr <= 1'b1;
		cmd(swd_pkg::CMD_BACKGROUND);
		cmd(swd_pkg::CMD_GO);
		u_pod.tx8(swd_pkg::CMD_WR_A);
		cmd(8'h5a);
		chk_cnt(n_wake + n_go + n_accw, 0);
		chk_val({halted, osc_on}, 2'b00);
		wr_ctrl(8'h80);
		chk_val(osc_on, 1'b1);
		cmd(swd_pkg::CMD_BACKGROUND);
		halt_m = 1'b1;
		chk_cnt(n_wake, 1);
		chk_val({halted, wd_hold}, 2'b11);
		rd_status();
		@(posedge mclk) low_pwr <= 1'b0;
		// Byte writes and reads; first with an edge gap just under the limit
		for (int i = 0; i < 3; i++) begin
			v16 = 16'($urandom);
			d8  = 8'($urandom);
			u_pod.tx8(swd_pkg::CMD_WR_BYTE);
			if (i == 0) u_pod.drv(1'b0, 1'b1, 480);
			if (i == 1) begin
				// Frozen enable outlasts the timeout; command must survive
				ce <= 1'b0;
				repeat (700) @(posedge mclk);
				ce <= 1'b1;
			end
			u_pod.tx16(v16);
			cmd(d8);
			chk_val(wr_a, v16);
			chk_val(wr_d, d8);
			u_pod.tx8(swd_pkg::CMD_RD_BYTE);
			u_pod.tx16(v16);
			u_pod.drv(1'b0, 1'b1, 20);
			u_pod.rx8(v8);
			chk_val(v8, d8);
		end
		// Timeout in mid-command aborts with no write
		lo = n_wr;
		u_pod.tx8(swd_pkg::CMD_WR_BYTE);
		u_pod.tx16(16'h0040);
		u_pod.drv(1'b0, 1'b1, 600);
		rd_status();
		chk_cnt(n_wr, lo);
		// Accumulator access and single step while halted
		@(posedge mclk) cpu_acc <= 8'($urandom);
		d8 = 8'($urandom);
		u_pod.tx8(swd_pkg::CMD_WR_A);
		cmd(d8);
		chk_cnt(n_accw, 1);
		chk_val(acc_wdata, d8);
		cmd(swd_pkg::CMD_RD_A);
		u_pod.rx8(v8);
		chk_val(v8, cpu_acc);
		cmd(swd_pkg::CMD_STEP);
		chk_cnt(n_step, 1);
		// Breakpoint write, read back, hit and miss
		v16 = 16'($urandom);
		u_pod.tx8(swd_pkg::CMD_WR_BKPT);
		u_pod.tx16(v16);
		u_pod.tx8(swd_pkg::CMD_RD_BKPT);
		u_pod.rx8(w16[15:8]);
		u_pod.rx8(w16[7:0]);
		chk_val(w16, v16);
		wr_ctrl(8'h82);
		@(posedge mclk);
		cpu_addr <= v16;
		addr_vld <= 1'b1;
		@(posedge mclk);
		cpu_addr <= ~v16;
		#1 chk_val(bkpt_hit, 1'b1);
		@(posedge mclk);
		addr_vld <= 1'b0;
		#1 chk_val(bkpt_hit, 1'b0);
		// Alternate clock stretches the sync answer
		wr_ctrl(8'h86);
		u_pod.tk = 4;
		u_pod.sync(lo);
		chk_cnt(lo, 128 * swd_pkg::ALT_DIV);
		u_pod.drv(1'b0, 1'b1, 20);
		rd_status();
		wr_ctrl(8'h82);
		u_pod.tk = 1;
		// Go leaves halted mode
		cmd(swd_pkg::CMD_GO);
		halt_m = 1'b0;
		chk_cnt(n_go, 1);
		chk_val(halted, 1'b0);
		rd_status();
		chk_cnt(n_conf, 0);
		results();
	end

	// Hang guard
	initial begin
		#1000000;
		error_cnt++;
		results();
	end
endmodule : swd_link_test
